// ===== verilog/swe_pkg.sv
/*
 * Shared constants for the subtract execution unit: register offsets,
 * instruction fields, status bit positions, reset values and phases.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package swe_pkg;

    // Register byte offsets
    localparam logic [3:0] OFF_INSTR   = 4'h0;
    localparam logic [3:0] OFF_ACC     = 4'h4;
    localparam logic [3:0] OFF_STAT    = 4'h8;
    localparam logic [3:0] OFF_BANK    = 4'hC;

    // Instruction fields
    localparam logic [7:0] OPC_LIT     = 8'h08;
    localparam logic [5:0] OPC_FILE    = 6'h17;
    localparam int         BIT_DEST    = 9;
    localparam int         BIT_BANK    = 8;
    localparam int         BIT_SPLIT   = 7;

    // Access bank halves
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;

    // Status word bit positions
    localparam int         ST_C        = 0;
    localparam int         ST_DC       = 1;
    localparam int         ST_Z        = 2;
    localparam int         ST_OV       = 3;
    localparam int         ST_N        = 4;
    localparam int         ST_BUSY     = 8;
    localparam int         ST_BADOP    = 9;

    // Reset values
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [3:0]  BANK_RST   = 4'h0;
    localparam logic [4:0]  FLAGS_RST  = 5'h00;
    localparam logic [15:0] INSTR_RST  = 16'h0000;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } swe_phase_t;

endpackage

// ===== verilog/swe_sub_alu.sv
/*
 * Combinational 8-bit subtractor: minuend minus subtrahend with the
 * carry (no borrow), digit carry, zero, overflow and negative flags.
 * Assumes operands are stable registers in the caller.
 */
`timescale 1ns/1ps

module swe_sub_alu #(
    parameter int DW = 8
) (
    // Operands
    input  wire logic [DW-1:0] minuend_i,
    input  wire logic [DW-1:0] subtrahend_i,
    // Result and flags
    output logic      [DW-1:0] diff_o,
    output logic               c_o,
    output logic               dc_o,
    output logic               z_o,
    output logic               ov_o,
    output logic               n_o
);

    logic [DW:0] full_diff;
    logic [4:0]  low_diff;

    assign full_diff = {1'b0, minuend_i} - {1'b0, subtrahend_i};
    assign low_diff  = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
    assign diff_o    = full_diff[DW-1:0];
    // Carry high means no borrow came out of bit 7
    assign c_o       = ~full_diff[DW];
    assign dc_o      = ~low_diff[4];
    assign z_o       = (full_diff[DW-1:0] == '0);
    assign n_o       = full_diff[DW-1];
    // Signed overflow: operand signs differ and result sign leaves the minuend's
    assign ov_o      = (minuend_i[DW-1] != subtrahend_i[DW-1])
                     && (full_diff[DW-1] != minuend_i[DW-1]);

endmodule

// ===== verilog/swe_exec_unit.sv
/*
 * Subtract execution unit: runs the literal-subtract and file-subtract
 * instructions over four quarter-phases, with a Wishbone register slave.
 * Assumes an external data memory that returns file_rdat_i combinationally
 * for the address on file_addr_o and writes on the edge while file_we_o.
 */
// Function
// - Literal subtract: immediate minus working register, result into working register.
// - Literal opcode 0000 1000 plus immediate; one cycle, working register written in Q4.
// - File subtract decoded from 0101 11, destination, bank bit, file address; file minus W.
// - Destination 0 writes difference to working register, file untouched.
// - Destination 1 writes difference back to the file, working register untouched.
// - Bank bit 0 addresses the quick-access bank, ignoring the bank pointer.
// - Bank bit 1 forms the file address from the bank pointer.
// - Positive nonzero result without borrow sets carry, clears zero.
// - Zero result sets zero and carry, clears negative.
// - Subtrahend above minuend stores the wrap, clears carry, sets negative unless it leads by over 128.
// - File subtract completes in one cycle, destination written in Q4.
`timescale 1ns/1ps

module swe_exec_unit #(
    parameter int DW = 8,
    parameter int AW = 4
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Data memory port
    output logic      [11:0]   file_addr_o,
    input  wire logic [DW-1:0] file_rdat_i,
    output logic               file_we_o,
    output logic      [DW-1:0] file_wdat_o
);

    function automatic logic is_lit(input logic [15:0] word);
        is_lit = (word[15:8] == swe_pkg::OPC_LIT);
    endfunction

    function automatic logic is_file(input logic [15:0] word);
        is_file = (word[15:10] == swe_pkg::OPC_FILE);
    endfunction

    swe_pkg::swe_phase_t phase;
    swe_pkg::swe_phase_t next_phase;

    localparam logic [DW-1:0] ACC_ZERO = '0;

    logic [15:0]   instr;
    logic [DW-1:0] acc;
    logic [3:0]    bank;
    logic [4:0]    flags;
    logic [4:0]    pend_flags;
    logic          badop;
    logic [DW-1:0] opa;
    logic [DW-1:0] opb;
    logic [DW-1:0] res;

    // Bus decode
    wire           bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write lands at the edge that samples ack high, where the master still holds it
    wire           bus_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire           busy      = (phase != swe_pkg::PH_IDLE);
    wire           hit_instr = (wb_adr_i == AW'(swe_pkg::OFF_INSTR));
    wire           hit_acc   = (wb_adr_i == AW'(swe_pkg::OFF_ACC));
    wire           hit_stat  = (wb_adr_i == AW'(swe_pkg::OFF_STAT));
    wire           hit_bank  = (wb_adr_i == AW'(swe_pkg::OFF_BANK));
    wire [15:0]    new_instr = wb_dat_i[15:0];
    // A half-written instruction word would run garbage, so both low lanes are needed
    wire           instr_wr  = bus_wr & hit_instr & (&wb_sel_i[1:0]) & ~busy;
    wire           new_ok    = is_lit(new_instr) | is_file(new_instr);
    wire           go        = instr_wr & new_ok;
    // Software writes to W and the bank pointer are dropped while an instruction runs
    wire           acc_wr    = bus_wr & hit_acc & wb_sel_i[0] & ~busy;
    wire           bank_wr   = bus_wr & hit_bank & wb_sel_i[0] & ~busy;

    // Instruction decode
    wire           op_lit    = is_lit(instr);
    wire           op_file   = is_file(instr);
    wire           dest_file = op_file & instr[swe_pkg::BIT_DEST];
    wire           use_bank  = instr[swe_pkg::BIT_BANK];
    wire [3:0]     acc_half  = instr[swe_pkg::BIT_SPLIT] ? swe_pkg::ACC_HI_BANK
                                                         : swe_pkg::ACC_LO_BANK;
    wire [11:0]    eff_addr  = use_bank ? {bank, instr[7:0]}
                                        : {acc_half, instr[7:0]};
    wire [DW-1:0]  minuend   = op_lit ? instr[DW-1:0] : file_rdat_i;

    // Read data; unmapped offsets still get an answer and read zero
    wire [31:0]    stat_word = {22'h000000, badop, busy, 3'h0, flags};
    wire [31:0]    rd_data   = hit_instr ? {16'h0000, instr} :
                               hit_acc   ? {24'h000000, acc} :
                               hit_stat  ? stat_word :
                               hit_bank  ? {28'h0000000, bank} : 32'h00000000;

    // Subtractor
    logic [DW-1:0] alu_diff;
    logic          alu_c;
    logic          alu_dc;
    logic          alu_z;
    logic          alu_ov;
    logic          alu_n;

    swe_sub_alu #(
        .DW           (DW)
    ) u_alu (
        .minuend_i    (opa),
        .subtrahend_i (opb),
        .diff_o       (alu_diff),
        .c_o          (alu_c),
        .dc_o         (alu_dc),
        .z_o          (alu_z),
        .ov_o         (alu_ov),
        .n_o          (alu_n)
    );

    wire [4:0]     alu_flags = {alu_n, alu_ov, alu_z, alu_dc, alu_c};

    // Quarter-phase sequencer
    always_comb begin
        case (phase)
            swe_pkg::PH_IDLE: next_phase = go ? swe_pkg::PH_Q1 : swe_pkg::PH_IDLE;
            swe_pkg::PH_Q1:   next_phase = swe_pkg::PH_Q2;
            swe_pkg::PH_Q2:   next_phase = swe_pkg::PH_Q3;
            swe_pkg::PH_Q3:   next_phase = swe_pkg::PH_Q4;
            swe_pkg::PH_Q4:   next_phase = swe_pkg::PH_IDLE;
            default:          next_phase = swe_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= swe_pkg::PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // Bus answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h00000000;
        end
    end

    // Instruction register and illegal-opcode flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr <= swe_pkg::INSTR_RST;
            badop <= 1'b0;
        end else if (instr_wr) begin
            instr <= new_instr;
            badop <= ~new_ok;
        end
    end

    // Q1 decodes and puts the file address out; Q2 reads the operand
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_addr_o <= 12'h000;
            opa         <= ACC_ZERO;
            opb         <= ACC_ZERO;
        end else begin
            if (phase == swe_pkg::PH_Q1 && op_file) begin
                file_addr_o <= eff_addr;
            end
            if (phase == swe_pkg::PH_Q2) begin
                opa <= minuend;
                opb <= acc;
            end
        end
    end

    // Q3 processes; the file write strobe stands for the whole of Q4
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res         <= ACC_ZERO;
            pend_flags  <= swe_pkg::FLAGS_RST;
            file_we_o   <= 1'b0;
            file_wdat_o <= ACC_ZERO;
        end else begin
            if (phase == swe_pkg::PH_Q3) begin
                res         <= alu_diff;
                pend_flags  <= alu_flags;
                file_we_o   <= dest_file;
                file_wdat_o <= alu_diff;
            end else begin
                file_we_o   <= 1'b0;
            end
        end
    end

    // Q4 commits the working register and flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc   <= swe_pkg::ACC_RST;
            flags <= swe_pkg::FLAGS_RST;
        end else if (phase == swe_pkg::PH_Q4) begin
            if (!dest_file) begin
                acc <= res;
            end
            flags <= pend_flags;
        end else if (acc_wr) begin
            acc <= wb_dat_i[DW-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank <= swe_pkg::BANK_RST;
        end else if (bank_wr) begin
            bank <= wb_dat_i[3:0];
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LIT_RESULT: assert property (
        (phase == swe_pkg::PH_Q4 && op_lit) |=>
            (acc == DW'($past(opa) - $past(opb)))
    ) else $error("literal subtract left a wrong working register");

    AST_LIT_TIMING: assert property (
        (go && is_lit(new_instr)) |=>
            phase == swe_pkg::PH_Q1 ##1 phase == swe_pkg::PH_Q2
            ##1 phase == swe_pkg::PH_Q3 ##1 phase == swe_pkg::PH_Q4
            ##1 phase == swe_pkg::PH_IDLE
    ) else $error("literal subtract did not finish in four phases");

    AST_FILE_DECODE: assert property (
        (instr_wr && new_instr[15:10] == swe_pkg::OPC_FILE) |=>
            (op_file && busy && opa == $past(opa))
    ) else $error("file subtract not decoded");

    AST_DEST_ACC: assert property (
        (phase == swe_pkg::PH_Q3 && op_file && !instr[swe_pkg::BIT_DEST]) |=>
            !file_we_o ##1 (acc == $past(res))
    ) else $error("destination 0 did not target the working register");

    AST_DEST_FILE: assert property (
        (phase == swe_pkg::PH_Q3 && dest_file) |=>
            (file_we_o && file_wdat_o == $past(alu_diff)) ##1
            (!file_we_o && acc == $past(acc, 2))
    ) else $error("destination 1 did not write the file only");

    AST_ACCESS_BANK: assert property (
        (phase == swe_pkg::PH_Q2 && op_file && !use_bank) |->
            (file_addr_o == {(instr[swe_pkg::BIT_SPLIT] ? swe_pkg::ACC_HI_BANK
                                                        : swe_pkg::ACC_LO_BANK), instr[7:0]})
    ) else $error("quick-access address used the bank pointer");

    AST_BANKED: assert property (
        (phase == swe_pkg::PH_Q2 && op_file && use_bank) |->
            (file_addr_o == {bank, instr[7:0]})
    ) else $error("banked address not formed from the bank pointer");

    AST_POSITIVE: assert property (
        (phase == swe_pkg::PH_Q4 && opa > opb) |=>
            (flags[swe_pkg::ST_C] && !flags[swe_pkg::ST_Z])
    ) else $error("positive result flags wrong");

    AST_ZERO: assert property (
        (phase == swe_pkg::PH_Q4 && opa == opb) |=>
            (flags[swe_pkg::ST_Z] && flags[swe_pkg::ST_C] && !flags[swe_pkg::ST_N])
    ) else $error("zero result flags wrong");

    AST_BORROW: assert property (
        (phase == swe_pkg::PH_Q4 && opa < opb) |=>
            (!flags[swe_pkg::ST_C] && flags[swe_pkg::ST_N] && !flags[swe_pkg::ST_Z])
    ) else $error("borrow result flags wrong");

    AST_FILE_TIMING: assert property (
        (phase == swe_pkg::PH_Q1 && dest_file) |->
            !file_we_o [*3] ##1 file_we_o ##1 (!file_we_o && !busy)
    ) else $error("file write not in the fourth phase");

    AST_OV_DC: assert property (
        (phase == swe_pkg::PH_Q4) |=>
            (flags[swe_pkg::ST_DC] == ($past(opa[3:0]) >= $past(opb[3:0])))
            && (flags[swe_pkg::ST_OV] == ($past(opa[DW-1]) != $past(opb[DW-1])
                && $past(res[DW-1]) != $past(opa[DW-1])))
    ) else $error("overflow or digit carry wrong");

    AST_BUS_ACK: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("bus answer not one cycle long");

    AST_RESET_QUIET: assert property (
        $past(rst_i) |-> (!wb_ack_o && !file_we_o && !busy && wb_dat_o == 32'h00000000)
    ) else $error("outputs not quiet after reset");

    AST_LIT_NO_FILE: assert property (
        (phase == swe_pkg::PH_Q3 && op_lit) |=> (!file_we_o ##1 !file_we_o)
    ) else $error("literal subtract wrote the data memory");

    // Idle means no memory traffic, so a stray strobe cannot corrupt a file register
    AST_IDLE_NO_WRITE: assert property (
        !busy |-> !file_we_o
    ) else $error("file write strobe outside an instruction");

    AST_BADOP_IDLE: assert property (
        (instr_wr && !new_ok) |=> (badop && !busy && instr == $past(new_instr))
    ) else $error("unknown opcode started an instruction");

    // The core's Q4 write must have no rival, so software writes are dropped while busy
    AST_BUSY_GUARD: assert property (
        (bus_wr && (hit_acc || hit_bank) && busy && phase != swe_pkg::PH_Q4) |=>
            (acc == $past(acc) && bank == $past(bank))
    ) else $error("register write accepted while busy");

    AST_READ_ACC: assert property (
        (bus_req && !wb_we_i && hit_acc) |=> (wb_dat_o == {24'h000000, $past(acc)})
    ) else $error("working register read back wrong");

    // The memory may latch the address at any time between file instructions
    AST_ADDR_HOLD: assert property (
        !(phase == swe_pkg::PH_Q1 && op_file) |=> (file_addr_o == $past(file_addr_o))
    ) else $error("file address moved outside the first phase");

    // Flags move only at the commit, so status reads between instructions are stable
    AST_FLAGS_HOLD: assert property (
        (phase != swe_pkg::PH_Q4) |=> (flags == $past(flags))
    ) else $error("flags changed outside the commit phase");

    // Covers for the main scenarios
    COV_LIT: cover property (phase == swe_pkg::PH_Q4 && op_lit);
    COV_DEST_ACC: cover property (phase == swe_pkg::PH_Q4 && op_file && !dest_file);
    COV_FILE_WR: cover property (file_we_o);
    COV_BORROW: cover property (phase == swe_pkg::PH_Q4 && opa < opb);
    COV_BADOP: cover property (instr_wr && !new_ok);

endmodule

// ===== bench/swe_exec_unit_test.sv
/*
 * Self-checking bench for the subtract execution unit: register bus tasks,
 * a small data memory on the file port and one task per scenario.
 * Assumes swe_pkg and swe_exec_unit are compiled before this file.
 */
`timescale 1ns/1ps

module swe_exec_unit_test;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [11:0] file_addr_o;
    logic [7:0]  file_rdat_i;
    logic        file_we_o;
    logic [7:0]  file_wdat_o;
    logic [7:0]  mem [0:4095];
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles   = 0;
    int          we_cnt   = 0;

    swe_exec_unit #(.DW(8), .AW(4)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .file_addr_o(file_addr_o), .file_rdat_i(file_rdat_i),
        .file_we_o(file_we_o), .file_wdat_o(file_wdat_o)
    );

    always #50 clk_i = ~clk_i;

    // Memory answers combinationally, as the core samples it at the end of Q2
    assign file_rdat_i = mem[file_addr_o];

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (file_we_o === 1'b1) begin
            mem[file_addr_o] <= file_wdat_o;
            we_cnt <= we_cnt + 1;
        end
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; only the global timeout ends the wait for ack
    task wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
            input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task wr(input logic [3:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb(1'b1, adr, 4'hF, dat, rd);
    endtask

    task rdc(input string what, input logic [3:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 4'hF, 32'h0, rd);
        chk(what, exp, rd);
    endtask

    function automatic logic [31:0] exp_st(input logic [7:0] m, input logic [7:0] s);
        logic [7:0]  d;
        logic [31:0] r;
        d = m - s;
        r = 32'h0;
        r[swe_pkg::ST_C]  = (m >= s);
        r[swe_pkg::ST_DC] = (m[3:0] >= s[3:0]);
        r[swe_pkg::ST_Z]  = (d == 8'h00);
        r[swe_pkg::ST_N]  = d[7];
        r[swe_pkg::ST_OV] = (m[7] != s[7]) && (d[7] != m[7]);
        return r;
    endfunction

    // Four-phase execution leaves exactly one status read that sees busy
    task run(input logic [15:0] ins);
        logic [31:0] rd;
        int          busy_n;
        wr(swe_pkg::OFF_INSTR, {16'h0, ins});
        busy_n = 0;
        do begin
            wb(1'b0, swe_pkg::OFF_STAT, 4'hF, 32'h0, rd);
            if (rd[swe_pkg::ST_BUSY] === 1'b1) busy_n++;
        end while (rd[swe_pkg::ST_BUSY] !== 1'b0);
        chk("busy reads", 32'h1, busy_n);
    endtask

    task t_regs;
        logic [31:0] rd;
        rdc("instr rst", swe_pkg::OFF_INSTR, 32'h0);
        rdc("acc rst", swe_pkg::OFF_ACC, 32'h0);
        rdc("stat rst", swe_pkg::OFF_STAT, 32'h0);
        rdc("bank rst", swe_pkg::OFF_BANK, 32'h0);
        rdc("unmapped", 4'h2, 32'h0);
        wr(swe_pkg::OFF_ACC, 32'hFFFFFF5A);
        rdc("acc width", swe_pkg::OFF_ACC, 32'h5A);
        wb(1'b1, swe_pkg::OFF_ACC, 4'h0, 32'h11, rd);
        wr(4'h6, 32'h77);
        rdc("acc kept", swe_pkg::OFF_ACC, 32'h5A);
        // A half-lane instruction write must be dropped
        wb(1'b1, swe_pkg::OFF_INSTR, 4'h1, 32'h0802, rd);
        rdc("instr sel", swe_pkg::OFF_INSTR, 32'h0);
        wr(swe_pkg::OFF_BANK, 32'hFF);
        rdc("bank width", swe_pkg::OFF_BANK, 32'hF);
    endtask

    task t_lit(input logic [7:0] k, input logic [7:0] w);
        logic [7:0] d;
        d = k - w;
        wr(swe_pkg::OFF_ACC, {24'h0, w});
        run({swe_pkg::OPC_LIT, k});
        rdc("lit acc", swe_pkg::OFF_ACC, {24'h0, d});
        rdc("lit stat", swe_pkg::OFF_STAT, exp_st(k, w));
    endtask

    task t_file(input logic d, input logic a, input logic [3:0] bank,
                input logic [7:0] f, input logic [7:0] mv, input logic [7:0] wv);
        logic [11:0] ad;
        logic [7:0]  df;
        int          w0;
        ad = a ? {bank, f} : {f[7] ? swe_pkg::ACC_HI_BANK : swe_pkg::ACC_LO_BANK, f};
        df = mv - wv;
        mem[ad] = mv;
        wr(swe_pkg::OFF_BANK, {28'h0, bank});
        wr(swe_pkg::OFF_ACC, {24'h0, wv});
        w0 = we_cnt;
        run({swe_pkg::OPC_FILE, d, a, f});
        chk("file addr", {20'h0, ad}, {20'h0, file_addr_o});
        chk("file data", {24'h0, d ? df : mv}, {24'h0, mem[ad]});
        chk("file writes", {31'h0, d}, we_cnt - w0);
        rdc("file acc", swe_pkg::OFF_ACC, {24'h0, d ? wv : df});
        rdc("file stat", swe_pkg::OFF_STAT, exp_st(mv, wv));
    endtask

    task t_bad_and_busy;
        logic [31:0] st;
        st = 32'h0;
        st[swe_pkg::ST_BADOP] = 1'b1;
        wr(swe_pkg::OFF_ACC, 32'h05);
        wr(swe_pkg::OFF_INSTR, 32'h1234);
        // Flags of the last file subtract stand through the refused opcode
        rdc("badop stat", swe_pkg::OFF_STAT, st | exp_st(8'h80, 8'h7F));
        rdc("badop instr", swe_pkg::OFF_INSTR, 32'h1234);
        rdc("badop acc", swe_pkg::OFF_ACC, 32'h05);
        wr(swe_pkg::OFF_INSTR, {16'h0, swe_pkg::OPC_LIT, 8'h09});
        wr(swe_pkg::OFF_ACC, 32'h99);
        repeat (4) @(posedge clk_i);
        rdc("busy acc", swe_pkg::OFF_ACC, 32'h04);
        rdc("good stat", swe_pkg::OFF_STAT, exp_st(8'h09, 8'h05));
    endtask

    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_lit(8'h02, 8'h01);
        t_lit(8'h02, 8'h02);
        t_lit(8'h02, 8'h03);
        t_lit(8'h80, 8'h01);
        t_lit(8'h7F, 8'hFF);
        t_file(1'b1, 1'b0, 4'h5, 8'h10, 8'h03, 8'h02);
        t_file(1'b0, 1'b0, 4'h5, 8'h10, 8'h02, 8'h02);
        t_file(1'b1, 1'b1, 4'h5, 8'h10, 8'h01, 8'h02);
        t_file(1'b0, 1'b1, 4'hA, 8'h90, 8'h50, 8'h21);
        t_file(1'b1, 1'b0, 4'h3, 8'h90, 8'h80, 8'h7F);
        t_bad_and_busy();
        wrap_up();
    end
endmodule
